// *** core/ptu_top.sv ***
// Purpose: Pseudo-random test pattern generator and detector with an
//          AHB-Lite register slave.
// Assumes: Path bit strobes are synchronous to hclk; bit position 0 is
//          the first transmitted (most significant) bit of a timeslot.
// Notes:   One register stage on each data path.
// Notes on behaviour
// - Direction bit puts generator on one path
// - Two-bit mode: unframed, 8-bit, 7-bit channels
// - Unframed mode touches every bit, ignores selection
// - Channel modes touch only selected timeslots
// - Seven-bit mode uses upper seven bits only
// - Sequence select: 2^11-1, 2^15-1, 2^20-1
// - Generator restarts on test enable rising
// - Error insert write flips exactly one bit
// - Generated invert applied before error insertion
// - Detector restarts on test enable rising
// - Matching extracted data sets sync status
// - Synced mismatch raises bit error event
// - Bit error flag plus enable drives interrupt
// - Over ten errors in 48 bits loses sync
// - Any sync change sets change flag; interrupt only if its enable is set
// - Extracted data invert applied before detector compare
// - Interrupt output active low while pending
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ptu_cfg.svh"
module ptu_top
   import ptu_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Transmit payload path
   input  wire logic        tx_bit_valid,
   input  wire logic        tx_bit_in,
   input  wire logic [4:0]  tx_chan,
   input  wire logic [2:0]  tx_bitpos,
   output logic             tx_bit_out,
   output logic             tx_bit_out_valid,
   // Receive payload path
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_bit_in,
   input  wire logic [4:0]  rx_chan,
   input  wire logic [2:0]  rx_bitpos,
   output logic             rx_bit_out,
   output logic             rx_bit_out_valid,
   // Performance monitor and interrupt
   output logic             bit_error_pulse,
   output logic             irq_n
);
   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0]  ctrl_reg;          // Sequence select, inverts
   logic        err_pend_reg;      // Single error waiting for a bit
   logic [1:0]  irq_en_reg;        // Sync change and bit error enables
   logic [1:0]  flags_reg;         // Sticky sync change and bit error
   logic [7:0]  testcfg_reg;       // Direction, mode, test enable
   logic [31:0] sel_reg;           // Per-timeslot test selection
   logic        te_d_reg;          // Test enable, one cycle late
   logic        wr_pend_reg;       // Write data phase pending
   logic [13:0] wr_addr_reg;       // Address of pending write
   // Field views
   logic [1:0]  sequence_select;
   logic        generated_pattern_invert;
   logic        extracted_data_invert;
   logic        pattern_direction_select;
   logic [1:0]  pattern_framing_mode;
   logic        test_enable;
   logic        te_rise;
   assign sequence_select          = ctrl_reg[`PTU_CTRL_SEQ_LO +: 2];
   assign generated_pattern_invert = ctrl_reg[`PTU_CTRL_GINV];
   assign extracted_data_invert    = ctrl_reg[`PTU_CTRL_EXTRACTED_DATA_INVERT];
   assign pattern_direction_select = testcfg_reg[`PTU_CFG_DIR];
   assign pattern_framing_mode     = testcfg_reg[`PTU_CFG_MODE_LO +: 2];
   assign test_enable              = testcfg_reg[`PTU_CFG_TEST_ENABLE];
   assign te_rise                  = test_enable & ~te_d_reg;
   // ----------------------------------------------------------------------
   // Sequence helpers
   // ----------------------------------------------------------------------
   // Feedback bit of the selected maximal-length sequence
   function automatic logic seq_fb(input ptu_lfsr_t s,
                                   input logic [1:0] seq);
      logic r;
      r = s[19] ^ s[16];
      if (seq == `PTU_SEQ_11) begin
         r = s[10] ^ s[8];
      end else if (seq == `PTU_SEQ_15) begin
         r = s[14] ^ s[13];
      end
      return r;
   endfunction
   // Whether the bit at chan/pos takes part in the test
   function automatic logic bit_used(input logic [1:0] mode,
                                     input logic [31:0] sel,
                                     input logic [4:0] chan,
                                     input logic [2:0] pos);
      logic r;
      r = 1'b1;
      if (mode == `PTU_MODE_CHAN8) begin
         r = sel[chan];
      end else if (mode == `PTU_MODE_CHAN7) begin
         r = sel[chan] & (pos != 3'h7);
      end
      return r;
   endfunction
   // ----------------------------------------------------------------------
   // Path steering
   // ----------------------------------------------------------------------
   logic        g_valid, d_valid, d_bit;
   logic [4:0]  g_chan, d_chan;
   logic [2:0]  g_pos, d_pos;
   logic        gen_take, det_take, gen_bit, rxb;
   ptu_lfsr_t   gen_lfsr_reg;      // Generator shift register
   // Generator on receive when direction is set, detector opposite
   always_comb begin
      g_valid = pattern_direction_select ? rx_bit_valid : tx_bit_valid;
      g_chan  = pattern_direction_select ? rx_chan      : tx_chan;
      g_pos   = pattern_direction_select ? rx_bitpos    : tx_bitpos;
      d_valid = pattern_direction_select ? tx_bit_valid : rx_bit_valid;
      d_chan  = pattern_direction_select ? tx_chan      : rx_chan;
      d_pos   = pattern_direction_select ? tx_bitpos    : rx_bitpos;
      d_bit   = pattern_direction_select ? tx_bit_in    : rx_bit_in;
   end
   // Nothing is replaced or extracted while the test is off
   assign gen_take = test_enable & ~te_rise & g_valid &
                     bit_used(pattern_framing_mode, sel_reg, g_chan, g_pos);
   assign det_take = test_enable & ~te_rise & d_valid &
                     bit_used(pattern_framing_mode, sel_reg, d_chan, d_pos);
   // Invert first, then the single error on top
   assign gen_bit = seq_fb(gen_lfsr_reg, sequence_select) ^
                    generated_pattern_invert ^ err_pend_reg;
   assign rxb     = d_bit ^ extracted_data_invert;
   // ----------------------------------------------------------------------
   // Generator
   // ----------------------------------------------------------------------
   // Seeded on enable rising, steps on each inserted bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gen_lfsr_reg <= `PTU_SEED;
         te_d_reg     <= 1'b0;
      end else begin
         te_d_reg <= test_enable;
         if (te_rise) begin
            gen_lfsr_reg <= `PTU_SEED;
         end else if (gen_take) begin
            gen_lfsr_reg <= {gen_lfsr_reg[18:0],
                             seq_fb(gen_lfsr_reg, sequence_select)};
         end
      end
   end
   // Data outputs, one register stage; bypass when not inserting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_bit_out       <= 1'b0;
         tx_bit_out_valid <= 1'b0;
         rx_bit_out       <= 1'b0;
         rx_bit_out_valid <= 1'b0;
      end else begin
         tx_bit_out_valid <= tx_bit_valid;
         rx_bit_out_valid <= rx_bit_valid;
         tx_bit_out <= (gen_take & ~pattern_direction_select) ?
                       gen_bit : tx_bit_in;
         rx_bit_out <= (gen_take & pattern_direction_select) ?
                       gen_bit : rx_bit_in;
      end
   end
   // ----------------------------------------------------------------------
   // Detector
   // ----------------------------------------------------------------------
   ptu_det_e    det_state;         // Idle, hunting or in sync
   ptu_lfsr_t   det_lfsr_reg;      // Regenerated reference
   logic [5:0]  run_cnt_reg;       // Consecutive matches while hunting
   logic [5:0]  win_cnt_reg;       // Position in the 48-bit window
   logic [3:0]  err_cnt_reg;       // Errors so far in the window
   logic        sync_status;
   logic        sync_d_reg;
   logic        pred, mism, lose;
   assign pred        = seq_fb(det_lfsr_reg, sequence_select);
   assign mism        = det_take & (rxb != pred);
   assign lose        = mism & (err_cnt_reg == `PTU_ERR_LIMIT);
   assign sync_status = (det_state == PTU_DET_SYNC);
   // Hunt loads received bits; sync free-runs and counts errors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         det_state       <= PTU_DET_IDLE;
         det_lfsr_reg    <= `PTU_SEED;
         run_cnt_reg     <= 6'h00;
         win_cnt_reg     <= 6'h00;
         err_cnt_reg     <= 4'h0;
         bit_error_pulse <= 1'b0;
      end else begin
         bit_error_pulse <= 1'b0;
         if (te_rise) begin
            det_state   <= PTU_DET_HUNT;
            run_cnt_reg <= 6'h00;
         end else if (det_take) begin
            case (det_state)
               PTU_DET_HUNT: begin
                  det_lfsr_reg <= {det_lfsr_reg[18:0], rxb};
                  // A zero register would lock onto a dead line
                  if (rxb == pred && det_lfsr_reg != 20'h0_0000) begin
                     run_cnt_reg <= run_cnt_reg + 6'h01;
                     if (run_cnt_reg == `PTU_SYNC_RUN - 6'h01) begin
                        det_state   <= PTU_DET_SYNC;
                        win_cnt_reg <= 6'h00;
                        err_cnt_reg <= 4'h0;
                     end
                  end else begin
                     run_cnt_reg <= 6'h00;
                  end
               end
               PTU_DET_SYNC: begin
                  det_lfsr_reg    <= {det_lfsr_reg[18:0], pred};
                  bit_error_pulse <= mism;
                  if (lose) begin
                     det_state   <= PTU_DET_HUNT;
                     run_cnt_reg <= 6'h00;
                  end else if (win_cnt_reg == `PTU_WIN_LAST) begin
                     win_cnt_reg <= 6'h00;
                     err_cnt_reg <= 4'h0;
                  end else begin
                     win_cnt_reg <= win_cnt_reg + 6'h01;
                     err_cnt_reg <= err_cnt_reg + {3'h0, mism};
                  end
               end
               default: begin
                  det_state <= PTU_DET_IDLE;
               end
            endcase
         end
      end
   end
   // ----------------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------------
   logic        acc;               // Valid address phase
   logic [13:0] a;
   logic [31:0] rd_next;
   assign acc       = hsel & hready & htrans[1];
   assign a         = haddr[13:0];
   assign hreadyout = 1'b1;        // No wait states
   assign hresp     = 1'b0;        // Always OKAY
   // Read data is formed in the address phase and held for the data phase
   always_comb begin
      rd_next = 32'h0000_0000;     // Unmapped reads as zero
      if (a == `PTU_ADDR_CTRL) begin
         rd_next = {24'h00_0000, ctrl_reg};
      end else if (a == `PTU_ADDR_STAT) begin
         rd_next = {29'h0, sync_status, irq_en_reg};
      end else if (a == `PTU_ADDR_FLAGS) begin
         rd_next = {30'h0, flags_reg};
      end else if (a == `PTU_ADDR_TESTCFG) begin
         rd_next = {24'h00_0000, testcfg_reg};
      end else if (a >= `PTU_ADDR_SEL0 && a <= `PTU_ADDR_SEL3) begin
         rd_next = {24'h00_0000, sel_reg[8*a[3:2] +: 8]};
      end
   end
   // Capture address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata      <= 32'h0000_0000;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 14'h0000;
      end else if (hready) begin
         wr_pend_reg <= acc & hwrite;
         wr_addr_reg <= a;
         if (acc && !hwrite) begin
            hrdata <= rd_next;
         end
      end
   end
   // Control registers, written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg    <= `PTU_RST_REG8;
         irq_en_reg  <= 2'h0;
         testcfg_reg <= `PTU_RST_REG8;
         sel_reg     <= `PTU_RST_SEL;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == `PTU_ADDR_CTRL) begin
            ctrl_reg <= hwdata[7:0] & 8'h1B; // Insert bit self-clears
         end else if (wr_addr_reg == `PTU_ADDR_STAT) begin
            irq_en_reg <= hwdata[1:0];
         end else if (wr_addr_reg == `PTU_ADDR_TESTCFG) begin
            testcfg_reg <= hwdata[7:0];
         end else if (wr_addr_reg >= `PTU_ADDR_SEL0 &&
                      wr_addr_reg <= `PTU_ADDR_SEL3) begin
            sel_reg[8*wr_addr_reg[3:2] +: 8] <= hwdata[7:0];
         end
      end
   end
   // Pending single error: armed by a write of one, spent on one bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_pend_reg <= 1'b0;
      end else if (wr_pend_reg && wr_addr_reg == `PTU_ADDR_CTRL &&
                   hwdata[`PTU_CTRL_ERRINS]) begin
         err_pend_reg <= 1'b1;
      end else if (gen_take) begin
         err_pend_reg <= 1'b0;
      end
   end
   // ----------------------------------------------------------------------
   // Interrupt flags
   // ----------------------------------------------------------------------
   logic [1:0] set_v, clr_v;
   assign set_v = {bit_error_pulse, sync_status != sync_d_reg};
   assign clr_v = (wr_pend_reg && wr_addr_reg == `PTU_ADDR_FLAGS) ?
                  hwdata[1:0] : 2'h0;
   // Sticky, write one to clear; a new event beats the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_reg  <= 2'h0;
         sync_d_reg <= 1'b0;
         irq_n      <= 1'b1;
      end else begin
         sync_d_reg <= sync_status;
         flags_reg  <= (flags_reg & ~clr_v) | set_v;
         irq_n      <= ~|(flags_reg & irq_en_reg);
      end
   end
   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 irq_n == !$past(|(flags_reg & irq_en_reg)))
      else $error("interrupt level does not follow pending flags");
   AST_BIT_ERROR_FLAG_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
      flags_reg[`PTU_FLAG_BITERR] && irq_en_reg[`PTU_STAT_BITERR_EN]
      |=> !irq_n)
      else $error("bit error interrupt not raised");
   AST_ERR_SYNC: assert property (@(posedge hclk) disable iff (!hresetn)
      bit_error_pulse |-> $past(sync_status) ##1 flags_reg[`PTU_FLAG_BITERR])
      else $error("bit error outside sync or not flagged");
   AST_SYNC_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(sync_status) |=> flags_reg[`PTU_FLAG_SYNCCH])
      else $error("sync change not flagged");
   AST_LOSS: assert property (@(posedge hclk) disable iff (!hresetn)
      sync_status && lose && !te_rise |=> !sync_status)
      else $error("sync kept after eleventh error");
   AST_IDLE_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
      !test_enable |=> tx_bit_out == $past(tx_bit_in) &&
                       rx_bit_out == $past(rx_bit_in))
      else $error("path altered while test disabled");
   AST_DIR_TX: assert property (@(posedge hclk) disable iff (!hresetn)
      pattern_direction_select |=> tx_bit_out == $past(tx_bit_in))
      else $error("transmit altered while generator on receive");
   AST_SEVEN: assert property (@(posedge hclk) disable iff (!hresetn)
      pattern_framing_mode == `PTU_MODE_CHAN7 && tx_bitpos == 3'h7
      |=> tx_bit_out == $past(tx_bit_in))
      else $error("seven-bit mode touched the last bit");
   AST_ONE_ERR: assert property (@(posedge hclk) disable iff (!hresetn)
      err_pend_reg && gen_take && !wr_pend_reg |=> !err_pend_reg)
      else $error("single error not spent on one bit");
endmodule // ptu_top
`default_nettype wire

// *** include/ptu_cfg.svh ***
// Purpose: Offsets, field positions, reset values and counts of the
//          pattern generator and detector.
// Assumes: Register indices are scaled by four to give byte addresses.
// Notes:   Definitions only.
`ifndef PTU_CFG_SVH
`define PTU_CFG_SVH
// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define PTU_IDX_CTRL        12'h071
`define PTU_IDX_STAT        12'h072
`define PTU_IDX_FLAGS       12'h073
`define PTU_IDX_TESTCFG     12'h0C7
`define PTU_IDX_SEL0        12'h0D0
`define PTU_ADDR_CTRL       14'h01C4
`define PTU_ADDR_STAT       14'h01C8
`define PTU_ADDR_FLAGS      14'h01CC
`define PTU_ADDR_TESTCFG    14'h031C
`define PTU_ADDR_SEL0       14'h0340
`define PTU_ADDR_SEL3       14'h034C
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTU_CTRL_SEQ_LO     0
`define PTU_CTRL_ERRINS     2
`define PTU_CTRL_GINV       3
`define PTU_CTRL_EXTRACTED_DATA_INVERT       4
`define PTU_STAT_SYNCCH_EN  0
`define PTU_STAT_BITERR_EN  1
`define PTU_STAT_SYNC       2
`define PTU_FLAG_SYNCCH     0
`define PTU_FLAG_BITERR     1
`define PTU_CFG_DIR         0
`define PTU_CFG_MODE_LO     1
`define PTU_CFG_TEST_ENABLE      3
// ----------------------------------------------------------------------
// Mode and sequence codes, reset values, counts
// ----------------------------------------------------------------------
`define PTU_MODE_UNFRAMED   2'h0
`define PTU_MODE_CHAN8      2'h1
`define PTU_MODE_CHAN7      2'h2
`define PTU_SEQ_11          2'h0
`define PTU_SEQ_15          2'h1
`define PTU_RST_REG8        8'h00
`define PTU_RST_SEL         32'h0000_0000
`define PTU_SEED            20'h0F_FFFF
`define PTU_WIN_LAST        6'h2F
`define PTU_ERR_LIMIT       4'hA
`define PTU_SYNC_RUN        6'h20
`endif

// *** include/ptu_pkg.sv ***
// Purpose: Types of the pattern generator and detector.
// Assumes: Nothing beyond the configuration header.
// Notes:   Types only; numbers live in ptu_cfg.svh.
package ptu_pkg;
   // Detector state
   typedef enum logic [1:0] {
      PTU_DET_IDLE,
      PTU_DET_HUNT,
      PTU_DET_SYNC
   } ptu_det_e;
   // Shift register of the longest sequence
   typedef logic [19:0] ptu_lfsr_t;
endpackage

// *** tb/ptu_path_model.sv ***
// Purpose: Payload path model that strobes bits into both paths.
// Assumes: One strobe every second cycle, 32 slots of 8 bits.
// Notes:   Checked path carries the generated path's output back.
`timescale 1ns/1ps
`default_nettype none
module ptu_path_model
   import ptu_pkg::*;
(
   // Clock, reset and loop choice
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       loop_dir,
   // Path outputs of the unit
   input  wire logic       tx_bit_out,
   input  wire logic       rx_bit_out,
   // Strobes towards the unit
   output logic            tx_bit_valid,
   output logic            tx_bit_in,
   output logic [4:0]      tx_chan,
   output logic [2:0]      tx_bitpos,
   output logic            rx_bit_valid,
   output logic            rx_bit_in,
   output logic [4:0]      rx_chan,
   output logic [2:0]      rx_bitpos
);
   logic [7:0] slot_reg;   // Slot and bit of the generated path
   logic [7:0] lag;        // Looped bit arrives one strobe late
   assign lag = slot_reg - 8'h01;
   assign {tx_chan, tx_bitpos} = loop_dir ? lag : slot_reg;
   assign {rx_chan, rx_bitpos} = loop_dir ? slot_reg : lag;
   assign rx_bit_valid = tx_bit_valid;
   // -------------------------------------------------------------
   // Strobes; data toggles between strobes so no stale bit passes
   // -------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_bit_valid <= 1'b0;
         slot_reg     <= 8'h00;
         tx_bit_in    <= 1'b0;
         rx_bit_in    <= 1'b0;
      end else if (!tx_bit_valid) begin
         tx_bit_valid <= 1'b1;
         slot_reg     <= slot_reg + 8'h01;
         tx_bit_in    <= loop_dir ? rx_bit_out : slot_reg[4];
         rx_bit_in    <= loop_dir ? slot_reg[4] : tx_bit_out;
      end else begin
         tx_bit_valid <= 1'b0;
         tx_bit_in    <= !tx_bit_in;
         rx_bit_in    <= !rx_bit_in;
      end
   end
endmodule // ptu_path_model
`default_nettype wire

// *** tb/tb_prbs_test_pattern_unit.sv ***
// Purpose: Self-checking bench of the test pattern unit.
// Assumes: Path model loops the generated path into the checked one.
// Notes:   Register rows first, then pattern, error and mode cases.
`timescale 1ns/1ps
`default_nettype none
`include "ptu_cfg.svh"
module tb_prbs_test_pattern_unit
   import ptu_pkg::*;
;
   typedef struct packed {logic w; logic [31:0] a, d;} ptu_row_s;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_n;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic tx_bit_valid, tx_bit_in, tx_bit_out, tx_bit_out_valid;
   logic rx_bit_valid, rx_bit_in, rx_bit_out, rx_bit_out_valid;
   logic [4:0]  tx_chan, rx_chan;
   logic [2:0]  tx_bitpos, rx_bitpos;
   logic bit_error_pulse, mon_on = 1'b0, tl_i, rl_i, tv = 1'b0, rv = 1'b0;
   logic [3:0]  cfg_now = 4'h0;  // Test config the monitor assumes
   logic [1:0]  sq = 2'h0;       // Sequence select in force
   logic [7:0]  tl_s, rl_s;
   logic [19:0] hist;            // Recent transmit output bits
   int failures, samples_checked, perr, pass_err, ea, eb, e0, e1, verr;
   int tn [3] = '{11, 15, 20};
   int tk [3] = '{9, 14, 17};
   logic [3:0] cfgs [4] = '{4'hA, 4'hC, 4'hD, 4'hE};
   ptu_row_s rows [13] = '{'{0, `PTU_ADDR_CTRL, 0},
      '{0, `PTU_ADDR_STAT, 0}, '{0, `PTU_ADDR_FLAGS, 0},
      '{0, `PTU_ADDR_TESTCFG, 0}, '{0, `PTU_ADDR_SEL0, 0},
      '{1, `PTU_ADDR_CTRL, 8'h1B}, '{0, `PTU_ADDR_CTRL, 8'h1B},
      '{1, `PTU_ADDR_STAT, 8'h07}, '{0, `PTU_ADDR_STAT, 8'h03},
      '{1, 12'h100, 8'hFF}, '{0, 12'h100, 0},
      '{1, `PTU_ADDR_CTRL, 0}, '{1, `PTU_ADDR_STAT, 0}};
   ptu_top ptu_top_i (.hsize(3'b010), .hready(hreadyout), .*);
   ptu_path_model ptu_path_model_i (.loop_dir(cfg_now[0]), .*);
   // -------------------------------------------------------------
   // Clock, watchdog and monitors
   // -------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      #(80_000 * 50);
      failures++;
      stop_test();
   end
   // Which bits the generator may own under the current config
   function automatic bit own(input logic [7:0] s);
      return cfg_now[3] && (cfg_now[2:1] inside {2'd0, 2'd3} ||
         (s[7:3] == 5'd1 && !(cfg_now[2:1] == 2'd2 && s[2:0] == 3'd7)));
   endfunction
   always @(posedge hclk) begin
      if (tx_bit_out_valid === 1'b1 && mon_on && tx_bit_out !== tl_i
          && !(own(tl_s) && !cfg_now[0])) pass_err++;
      if (rx_bit_out_valid === 1'b1 && mon_on && rx_bit_out !== rl_i
          && !(own(rl_s) && cfg_now[0])) pass_err++;
      // Output strobes trail the input strobes by one cycle
      if (mon_on && {tx_bit_out_valid, rx_bit_out_valid} !== {tv, rv}) verr++;
      {tv, rv} = {tx_bit_valid, rx_bit_valid};
      if (tx_bit_valid) {tl_i, tl_s} = {tx_bit_in, tx_chan, tx_bitpos};
      if (rx_bit_valid) {rl_i, rl_s} = {rx_bit_in, rx_chan, rx_bitpos};
      if (bit_error_pulse === 1'b1) perr++;
      // Either tap reading of the polynomial is accepted
      if (tx_bit_out_valid === 1'b1) begin
         if (tx_bit_out !== (hist[tn[sq]-1] ^ hist[tk[sq]-1])) ea++;
         if (tx_bit_out !== (hist[tn[sq]-1] ^ hist[tn[sq]-tk[sq]-1])) eb++;
         hist = {hist[18:0], tx_bit_out};
      end
   end
   // -------------------------------------------------------------
   // Bus and compare tasks
   // -------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input string n, input logic [31:0] a, m, e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(n, e, r & m);
   endtask
   // Monitor is paused while the config write lands
   task automatic setcfg(input logic [3:0] c);
      mon_on <= 1'b0;
      wr(`PTU_ADDR_TESTCFG, {28'h0, c});
      repeat (4) @(posedge hclk);
      cfg_now <= c;
      mon_on <= 1'b1;
   endtask
   task automatic wait_sync(input logic v);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         bus(1'b0, `PTU_ADDR_STAT, 32'h0, r);
         n++;
      end while (r[2] !== v && n < 6000);
      chk("sync_status", {31'h0, v}, {31'h0, r[2]});
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(posedge hclk);
      chk("irq_n", {31'h0, e}, {31'h0, irq_n});
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin : main_seq
      logic [31:0] r;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      mon_on <= 1'b1;
      irq_is(1'b1);
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d, r);
         if (!rows[i].w) chk("register", rows[i].d, r);
      end
      for (int s = 0; s < 3; s++) begin
         setcfg(4'h0);
         wr(`PTU_ADDR_CTRL, 32'(s));
         sq <= 2'(s);
         setcfg(4'h8);
         wait_sync(1'b1);
         {e0, e1} = {ea, eb};
         repeat (400) @(posedge hclk);
         chk("sequence", 0, 32'(!(ea == e0 || eb == e1)));
         rd("flags", `PTU_ADDR_FLAGS, 1, 1);
         wr(`PTU_ADDR_FLAGS, 3);
      end
      e0 = perr;
      wr(`PTU_ADDR_CTRL, 32'h6);
      repeat (100) @(posedge hclk);
      chk("bit_error_pulse", 1, perr - e0);
      rd("ctrl", `PTU_ADDR_CTRL, 32'hFF, 2);
      rd("flags", `PTU_ADDR_FLAGS, 2, 2);
      irq_is(1'b1);
      wr(`PTU_ADDR_STAT, 2);
      irq_is(1'b0);
      wr(`PTU_ADDR_FLAGS, 2);
      irq_is(1'b1);
      wr(`PTU_ADDR_STAT, 1);
      wr(`PTU_ADDR_CTRL, 32'hA);
      wait_sync(1'b0);
      rd("flags", `PTU_ADDR_FLAGS, 1, 1);
      irq_is(1'b0);
      wr(`PTU_ADDR_FLAGS, 3);
      wr(`PTU_ADDR_CTRL, 32'h1A);
      wait_sync(1'b1);
      rd("flags", `PTU_ADDR_FLAGS, 1, 1);
      wr(`PTU_ADDR_FLAGS, 3);
      wr(`PTU_ADDR_SEL0, 2);
      foreach (cfgs[i]) begin
         setcfg(4'h0);
         setcfg(cfgs[i]);
         wait_sync(1'b1);
      end
      setcfg(4'h0);
      chk("passthrough", 0, pass_err);
      chk("bit_out_valid", 0, verr);
      chk("hresp", 0, {31'h0, hresp});
      stop_test();
   end
endmodule // tb_prbs_test_pattern_unit
`default_nettype wire
